// >>> mcb_pkg.sv
// Notes on behaviour
// RULE1: Enable register has 64 flags; a set flag enables reporting of its error.
// RULE2: Writes leave unimplemented enable bits unchanged; only implemented bits take written values.
// RULE3: Legacy mode accepts only all-ones or all-zeros enables; first bank stays untouched.
// RULE4: Status clears only on an all-zero write; any one bit raises a protection fault.
// RULE5: Status 15:0 holds the architectural code, 31:16 the model-specific code.
// RULE6: With capability 10, status 52:38 counts corrected errors until software clears it.
// RULE7: Status bit 52 is a sticky counter overflow, cleared only by software.
// RULE8: Status 56:53 are architectural only with capability 11; otherwise implementation-specific.
// RULE9: With capabilities 11 and 24, bit 56 signals recoverable error, bit 55 action required.
// RULE10: Corrected errors report 54:53 as none, green, yellow; uncorrected leave it undefined.
// RULE11: Bit 57 set when processor context may be corrupted, clear otherwise.
// RULE12: Bit 58 set only when the address register holds the failing address.
// RULE13: Bit 59 set only when the auxiliary register holds extra error details.
// RULE14: Bit 60 set when the logged error had its enable flag set.
// RULE15: Bit 61 set for uncorrected errors, clear for corrected ones.
// RULE16: Bit 62 set when an error arrives with valid already set; software clears it.
// RULE17: Bit 63 set when valid information is logged; software alone clears it.
// RULE18: Enabled beats disabled, uncorrected beats corrected, never uncorrected over valid uncorrected; code lets an enabled one replace a disabled one.
// RULE19: Among corrected errors yellow beats green or untracked; otherwise the newer wins.
// RULE20: On overflow the bank holds wholly new or wholly first event, overflow set.
// RULE21: Unmonitored sources post colour code 00; green or yellow only when monitored.
// RULE22: Absent address register faults on every access; present one clears only on zero.
// RULE23: Error sources strobe an event with its details; the bank updates that same edge.
`default_nettype none
package mcb_pkg;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned CNT_W = 15;
  localparam int unsigned ST_MCA_LSB = 0;
  localparam int unsigned ST_MODEL_LSB = 16;
  localparam int unsigned ST_CNT_LSB = 38;
  localparam int unsigned ST_COLOR_LSB = 53;
  localparam int unsigned ST_AR = 55;
  localparam int unsigned ST_SIG = 56;
  localparam int unsigned ST_PCC = 57;
  localparam int unsigned ST_ADDRESS_VALID_FLAG = 58;
  localparam int unsigned ST_EXTRA_INFO_VALID_FLAG = 59;
  localparam int unsigned ST_EN = 60;
  localparam int unsigned ST_UC = 61;
  localparam int unsigned ST_OVER = 62;
  localparam int unsigned ST_VAL = 63;
  localparam int unsigned CAP_CNT_BIT = 10;
  localparam int unsigned CAP_TES_BIT = 11;
  localparam int unsigned CAP_SER_BIT = 24;
  localparam logic [1:0] COLOR_NONE = 2'h0;
  localparam logic [1:0] COLOR_GREEN = 2'h1;
  localparam logic [1:0] COLOR_YELLOW = 2'h2;
  localparam logic [DATA_W-1:0] ENABLE_RST = 64'h0000000000000000;
  localparam logic [DATA_W-1:0] ADDRESS_RST = 64'h0000000000000000;
  localparam logic [CNT_W-1:0] CNT_RST = 15'h0000;
  localparam logic [DATA_W-1:0] ENABLE_IMPL_DEFAULT = 64'hFFFFFFFFFFFFFFFF;

  typedef enum logic [1:0] {MCB_SEL_ENABLE, MCB_SEL_STATUS, MCB_SEL_ADDRESS, MCB_SEL_NONE} mcb_sel_t;

  typedef struct packed {
    logic [15:0] mca_code;
    logic [15:0] model_code;
    logic [1:0] color;
    logic action_required_flag;
    logic recoverable_uncorrected_error;
    logic context_corrupt_flag;
    logic address_valid_flag;
    logic extra_info_valid_flag;
    logic enabled;
    logic uncorrected_flag;
  } mcb_entry_t;

  localparam mcb_entry_t ENTRY_RST = '0;
endpackage
`default_nettype wire

// >>> mcb_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcb_arb_if;
  import mcb_pkg::*;
  logic old_valid;
  mcb_entry_t old_e;
  mcb_entry_t new_e;
  logic take_new;
  modport bank (output old_valid, output old_e, output new_e, input take_new);
  modport arb (input old_valid, input old_e, input new_e, output take_new);
endinterface
`default_nettype wire

// >>> mcb_overwrite_arb.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_overwrite_arb (
  mcb_arb_if.arb arb
);
  import mcb_pkg::*;

  always_comb begin
    if (!arb.old_valid) begin
      arb.take_new = 1'b1;
    end else if (arb.new_e.enabled != arb.old_e.enabled) begin
      arb.take_new = arb.new_e.enabled; // RULE18
    end else if (arb.old_e.uncorrected_flag) begin
      // With equal enable flags a valid uncorrected entry is kept, even against another one
      arb.take_new = 1'b0; // RULE18
    end else if (arb.new_e.uncorrected_flag) begin
      arb.take_new = 1'b1; // RULE18
    end else if (arb.old_e.color == COLOR_YELLOW && arb.new_e.color != COLOR_YELLOW) begin
      arb.take_new = 1'b0; // RULE19
    end else begin
      // Yellow after yellow may keep either; the newer is kept
      arb.take_new = 1'b1; // RULE19
    end
  end
endmodule
`default_nettype wire

// >>> mcb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_bank #(
  parameter logic [63:0] ENABLE_IMPL = mcb_pkg::ENABLE_IMPL_DEFAULT,
  parameter bit ADDR_IMPL = 1'b1,
  parameter bit MISC_IMPL = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [mcb_pkg::DATA_W-1:0] global_capability_register_i,
  input wire logic legacy_mode_i,
  input wire logic first_bank_i,
  input wire logic msr_req_i,
  input wire logic msr_we_i,
  input wire mcb_pkg::mcb_sel_t msr_sel_i,
  input wire logic [mcb_pkg::DATA_W-1:0] msr_wdata_i,
  output logic msr_ack_o,
  output logic msr_gp_fault_o,
  output logic [mcb_pkg::DATA_W-1:0] msr_rdata_o,
  input wire logic evt_valid_i,
  input wire logic [5:0] evt_src_idx_i,
  input wire logic [15:0] evt_mca_code_i,
  input wire logic [15:0] evt_model_code_i,
  input wire logic evt_uc_i,
  input wire logic evt_pcc_i,
  input wire logic evt_monitored_i,
  input wire logic [1:0] evt_color_i,
  input wire logic evt_signal_i,
  input wire logic evt_ar_i,
  input wire logic evt_addr_valid_i,
  input wire logic [mcb_pkg::DATA_W-1:0] evt_addr_i,
  input wire logic evt_misc_valid_i
);
  import mcb_pkg::*;

  logic [DATA_W-1:0] ctl_reg, ctl_next;
  mcb_entry_t entry_reg, entry_next;
  logic val_reg, val_next;
  logic over_reg, over_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0] addr_reg, addr_next;
  logic ack_reg, ack_next;
  logic gp_reg, gp_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic status_clr;
  logic cap_cnt, cap_tes, cap_ser;
  mcb_arb_if arb_if ();

  assign cap_cnt = global_capability_register_i[CAP_CNT_BIT];
  assign cap_tes = global_capability_register_i[CAP_TES_BIT];
  assign cap_ser = global_capability_register_i[CAP_SER_BIT];

  function automatic logic is_write(input logic req, input logic we, input mcb_sel_t sel, input mcb_sel_t which);
    is_write = req && we && (sel == which);
  endfunction

  // Software's view of the status word, gated by the capability bits
  function automatic logic [DATA_W-1:0] status_view(input mcb_entry_t e, input logic val, input logic over,
                                                     input logic [CNT_W-1:0] cnt, input logic c_cnt,
                                                     input logic c_tes, input logic c_ser);
    logic [DATA_W-1:0] v;
    v = '0;
    v[ST_MCA_LSB +: 16] = e.mca_code; // RULE5
    v[ST_MODEL_LSB +: 16] = e.model_code; // RULE5
    if (c_cnt) begin
      v[ST_CNT_LSB +: CNT_W] = cnt; // RULE6
    end
    if (c_tes) begin
      v[ST_COLOR_LSB +: 2] = e.color; // RULE8 RULE10
      if (c_ser) begin
        v[ST_AR] = e.action_required_flag; // RULE9
        v[ST_SIG] = e.recoverable_uncorrected_error; // RULE9
      end
    end
    v[ST_PCC] = e.context_corrupt_flag; // RULE11
    v[ST_ADDRESS_VALID_FLAG] = e.address_valid_flag; // RULE12
    v[ST_EXTRA_INFO_VALID_FLAG] = e.extra_info_valid_flag; // RULE13
    v[ST_EN] = e.enabled; // RULE14
    v[ST_UC] = e.uncorrected_flag; // RULE15
    v[ST_OVER] = over; // RULE16
    v[ST_VAL] = val; // RULE17
    status_view = v;
  endfunction

  // Event capture; the colour field is forced to untracked for unmonitored or uncorrected sources
  always_comb begin
    arb_if.new_e.mca_code = evt_mca_code_i; // RULE23
    arb_if.new_e.model_code = evt_model_code_i;
    arb_if.new_e.color = (evt_monitored_i && !evt_uc_i && evt_color_i != 2'h3) ? evt_color_i : COLOR_NONE; // RULE21
    arb_if.new_e.action_required_flag = evt_ar_i;
    arb_if.new_e.recoverable_uncorrected_error = evt_signal_i;
    arb_if.new_e.context_corrupt_flag = evt_pcc_i; // RULE11
    arb_if.new_e.address_valid_flag = evt_addr_valid_i && ADDR_IMPL; // RULE12
    arb_if.new_e.extra_info_valid_flag = evt_misc_valid_i && MISC_IMPL; // RULE13
    arb_if.new_e.enabled = ctl_reg[evt_src_idx_i]; // RULE1 RULE14
    arb_if.new_e.uncorrected_flag = evt_uc_i; // RULE15
  end

  assign status_clr = is_write(msr_req_i, msr_we_i, msr_sel_i, MCB_SEL_STATUS) && (msr_wdata_i == '0);
  // A clear in the same cycle as an event lets the event land in the emptied bank
  assign arb_if.old_valid = val_reg && !status_clr;
  assign arb_if.old_e = entry_reg;

  mcb_overwrite_arb u_arb (
    .arb(arb_if.arb)
  );

  always_comb begin
    ctl_next = ctl_reg;
    entry_next = entry_reg;
    val_next = val_reg;
    over_next = over_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    ack_next = 1'b0;
    gp_next = 1'b0;
    rdata_next = rdata_reg;
    if (msr_req_i) begin
      ack_next = 1'b1;
      rdata_next = '0;
      unique case (msr_sel_i)
        MCB_SEL_ENABLE: begin
          if (!msr_we_i) begin
            rdata_next = ctl_reg;
          end else if (legacy_mode_i) begin
            if (msr_wdata_i != '0 && msr_wdata_i != '1) begin
              gp_next = 1'b1; // RULE3
            end else if (!first_bank_i) begin
              ctl_next = msr_wdata_i & ENABLE_IMPL; // RULE3
            end
          end else begin
            ctl_next = (ctl_reg & ~ENABLE_IMPL) | (msr_wdata_i & ENABLE_IMPL); // RULE1 RULE2
          end
        end
        MCB_SEL_STATUS: begin
          if (!msr_we_i) begin
            rdata_next = status_view(entry_reg, val_reg, over_reg, cnt_reg, cap_cnt, cap_tes, cap_ser);
          end else if (msr_wdata_i != '0) begin
            gp_next = 1'b1; // RULE4
          end else begin
            entry_next = ENTRY_RST; // RULE4
            val_next = 1'b0; // RULE17
            over_next = 1'b0; // RULE16
            cnt_next = CNT_RST; // RULE6 RULE7
          end
        end
        MCB_SEL_ADDRESS: begin
          if (!ADDR_IMPL) begin
            gp_next = 1'b1; // RULE22
          end else if (!msr_we_i) begin
            rdata_next = addr_reg;
          end else if (msr_wdata_i != '0) begin
            gp_next = 1'b1; // RULE22
          end else begin
            addr_next = ADDRESS_RST; // RULE22
          end
        end
        MCB_SEL_NONE: begin
          gp_next = 1'b1;
        end
      endcase
    end
    if (evt_valid_i) begin
      if (cap_cnt && !evt_uc_i) begin
        // Low bits wrap; the top bit records that a wrap ever happened
        cnt_next[CNT_W-2:0] = cnt_next[CNT_W-2:0] + 14'h0001; // RULE6
        if (&cnt_next[CNT_W-2:0] == 1'b0 && &cnt_reg[CNT_W-2:0] && !status_clr) begin
          cnt_next[CNT_W-1] = 1'b1; // RULE7
        end
      end
      if (arb_if.take_new) begin
        entry_next = arb_if.new_e; // RULE20
        if (arb_if.new_e.address_valid_flag) begin
          addr_next = evt_addr_i; // RULE12
        end
      end
      val_next = 1'b1; // RULE17
      if (arb_if.old_valid) begin
        over_next = 1'b1; // RULE16 RULE20
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctl_reg <= ENABLE_RST;
      entry_reg <= ENTRY_RST;
      val_reg <= 1'b0;
      over_reg <= 1'b0;
      cnt_reg <= CNT_RST;
      addr_reg <= ADDRESS_RST;
      ack_reg <= 1'b0;
      gp_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
      entry_reg <= entry_next;
      val_reg <= val_next;
      over_reg <= over_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      ack_reg <= ack_next;
      gp_reg <= gp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign msr_ack_o = ack_reg;
  assign msr_gp_fault_o = gp_reg;
  assign msr_rdata_o = rdata_reg;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  enable_write_mask_a: assert property ( // RULE2
    is_write(msr_req_i, msr_we_i, msr_sel_i, MCB_SEL_ENABLE) && !legacy_mode_i
    |=> ctl_reg == (($past(ctl_reg) & ~ENABLE_IMPL) | ($past(msr_wdata_i) & ENABLE_IMPL)) && !msr_gp_fault_o
  ) else $error("enable write did not respect implemented bits");

  legacy_value_a: assert property ( // RULE3
    is_write(msr_req_i, msr_we_i, msr_sel_i, MCB_SEL_ENABLE) && legacy_mode_i
    && msr_wdata_i != '0 && msr_wdata_i != '1 |=> msr_gp_fault_o && $stable(ctl_reg)
  ) else $error("legacy enable write of mixed value accepted");

  first_bank_lock_a: assert property ( // RULE3
    legacy_mode_i && first_bank_i |=> $stable(ctl_reg)
  ) else $error("first bank enable register altered in legacy mode");

  status_fault_a: assert property ( // RULE4
    is_write(msr_req_i, msr_we_i, msr_sel_i, MCB_SEL_STATUS) && msr_wdata_i != '0 && !evt_valid_i
    |=> msr_gp_fault_o && msr_ack_o && $stable(val_reg) && $stable(entry_reg)
  ) else $error("non-zero status write not faulted");

  valid_over_a: assert property ( // RULE16
    evt_valid_i && val_reg && !status_clr |=> val_reg && over_reg
  ) else $error("second event did not set overflow");

  uc_retained_a: assert property ( // RULE18
    evt_valid_i && val_reg && entry_reg.uncorrected_flag && !status_clr
    && (arb_if.new_e.enabled == entry_reg.enabled) |=> $stable(entry_reg)
  ) else $error("valid uncorrected entry overwritten");

  yellow_kept_a: assert property ( // RULE19
    evt_valid_i && val_reg && !status_clr && !entry_reg.uncorrected_flag && !evt_uc_i
    && entry_reg.color == COLOR_YELLOW && arb_if.new_e.color != COLOR_YELLOW
    && entry_reg.enabled == arb_if.new_e.enabled |=> entry_reg.mca_code == $past(entry_reg.mca_code)
  ) else $error("yellow entry replaced by lower colour");

  corrected_count_a: assert property ( // RULE6
    evt_valid_i && cap_cnt && !evt_uc_i && !status_clr
    |=> cnt_reg[CNT_W-2:0] == $past(cnt_reg[CNT_W-2:0]) + 14'h0001
  ) else $error("corrected error count did not advance");

  sticky_overflow_a: assert property ( // RULE7
    cnt_reg[CNT_W-1] && !status_clr |=> cnt_reg[CNT_W-1]
  ) else $error("count overflow bit lost");

  untracked_colour_a: assert property ( // RULE21
    evt_valid_i && !evt_monitored_i && arb_if.take_new |=> entry_reg.color == COLOR_NONE
  ) else $error("unmonitored source posted a colour");

  addr_absent_a: assert property ( // RULE22
    msr_req_i && msr_sel_i == MCB_SEL_ADDRESS && !ADDR_IMPL |=> msr_gp_fault_o
  ) else $error("absent address register access not faulted");

  enabled_flag_a: assert property ( // RULE14
    evt_valid_i && !val_reg |=> entry_reg.enabled == $past(ctl_reg[evt_src_idx_i])
  ) else $error("enabled flag does not match enable register");

  code_capture_a: assert property ( // RULE5
    evt_valid_i && !val_reg
    |=> entry_reg.mca_code == $past(evt_mca_code_i) && entry_reg.model_code == $past(evt_model_code_i)
  ) else $error("error codes not captured from the event");

  valid_set_a: assert property ( // RULE17
    evt_valid_i |=> val_reg
  ) else $error("valid flag not set by an event");

  valid_hold_a: assert property ( // RULE17
    val_reg && !status_clr |=> val_reg
  ) else $error("valid flag dropped without a status clear");

  over_hold_a: assert property ( // RULE16
    over_reg && !status_clr |=> over_reg
  ) else $error("overflow flag dropped without a status clear");

  uc_flag_a: assert property ( // RULE15
    evt_valid_i && !val_reg |=> entry_reg.uncorrected_flag == $past(evt_uc_i)
  ) else $error("uncorrected flag does not match the event");

  pcc_flag_a: assert property ( // RULE11
    evt_valid_i && !val_reg |=> entry_reg.context_corrupt_flag == $past(evt_pcc_i)
  ) else $error("context corrupt flag does not match the event");

  addr_capture_a: assert property ( // RULE12
    ADDR_IMPL && evt_valid_i && !val_reg && evt_addr_valid_i
    |=> entry_reg.address_valid_flag && addr_reg == $past(evt_addr_i)
  ) else $error("failing address not captured");

  misc_flag_a: assert property ( // RULE13
    evt_valid_i && !val_reg
    |=> entry_reg.extra_info_valid_flag == ($past(evt_misc_valid_i) && MISC_IMPL)
  ) else $error("extra information flag set without the register");

  reserved_colour_a: assert property ( // RULE10
    entry_reg.color != 2'h3
  ) else $error("reserved colour code stored");

  uc_colour_a: assert property ( // RULE10
    evt_valid_i && evt_uc_i && arb_if.take_new |=> entry_reg.color == COLOR_NONE
  ) else $error("uncorrected entry carries a colour");

  over_retain_a: assert property ( // RULE20
    evt_valid_i && val_reg && !status_clr && !arb_if.take_new |=> $stable(entry_reg) && over_reg
  ) else $error("retained entry was partly overwritten");

  counter_hidden_a: assert property ( // RULE6
    msr_req_i && !msr_we_i && msr_sel_i == MCB_SEL_STATUS && !cap_cnt
    |=> msr_rdata_o[ST_CNT_LSB +: CNT_W] == '0
  ) else $error("count field visible without its capability");

  tes_hidden_a: assert property ( // RULE8
    msr_req_i && !msr_we_i && msr_sel_i == MCB_SEL_STATUS && !cap_tes
    |=> msr_rdata_o[ST_COLOR_LSB +: 4] == 4'h0
  ) else $error("threshold field visible without its capability");

  ser_hidden_a: assert property ( // RULE9
    msr_req_i && !msr_we_i && msr_sel_i == MCB_SEL_STATUS && !cap_ser
    |=> msr_rdata_o[ST_AR +: 2] == 2'h0
  ) else $error("recovery bits visible without their capability");

  addr_write_fault_a: assert property ( // RULE22
    is_write(msr_req_i, msr_we_i, msr_sel_i, MCB_SEL_ADDRESS) && msr_wdata_i != '0 && !evt_valid_i
    |=> msr_gp_fault_o && $stable(addr_reg)
  ) else $error("non-zero address write not faulted");

  status_clear_a: assert property ( // RULE4
    status_clr && !evt_valid_i
    |=> !val_reg && !over_reg && cnt_reg == CNT_RST && msr_ack_o && !msr_gp_fault_o
  ) else $error("zero status write did not clear the bank");

  enable_read_a: assert property ( // RULE1
    msr_req_i && !msr_we_i && msr_sel_i == MCB_SEL_ENABLE |=> msr_rdata_o == $past(ctl_reg)
  ) else $error("enable read does not return the enable register");

  overflow_event_c: cover property (evt_valid_i && val_reg ##1 over_reg);
  count_wrap_c: cover property (cnt_reg[CNT_W-1]);
  status_clear_c: cover property (status_clr && val_reg ##1 !val_reg);
  uc_over_corrected_c: cover property (evt_valid_i && evt_uc_i && val_reg && !entry_reg.uncorrected_flag);
endmodule
`default_nettype wire

// >>> mcb_err_src.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_err_src (
  input wire logic core_clk_i,
  output logic evt_valid_o,
  output logic [5:0] idx_o,
  output logic [31:0] code_o,
  output logic [6:0] flag_o,
  output logic [1:0] color_o,
  output logic [63:0] addr_o
);
  initial begin
    evt_valid_o = 1'b0;
    idx_o = 6'h00;
    code_o = 32'h0;
    flag_o = 7'h00;
    color_o = 2'h0;
    addr_o = 64'h0;
  end

  // Flags: 0 uc, 1 pcc, 2 monitored, 3 addr valid, 4 signal, 5 action, 6 misc
  task automatic post(input logic [5:0] i, input logic [31:0] c, input logic [6:0] f,
                      input logic [1:0] col, input logic [63:0] a);
    @(posedge core_clk_i);
    evt_valid_o <= 1'b1;
    idx_o <= i;
    code_o <= c;
    flag_o <= f;
    // Colour goes out raw; the bank must drop it for unmonitored sources
    color_o <= col;
    addr_o <= a;
    @(posedge core_clk_i);
    // Inverted leftovers so a stale sample never looks right
    evt_valid_o <= 1'b0;
    idx_o <= ~i;
    code_o <= ~c;
    flag_o <= ~f;
    color_o <= ~col;
    addr_o <= ~a;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mcb_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [63:0] cap = 64'h0000000001000C00;
  logic legacy = 1'b0;
  logic first = 1'b0;
  logic msr_req_i = 1'b0;
  logic msr_we_i = 1'b0;
  mcb_sel_t msr_sel_i = MCB_SEL_NONE;
  logic [63:0] msr_wdata_i = 64'h0;
  logic msr_ack_o, msr_gp_fault_o;
  logic [63:0] msr_rdata_o, addr;
  logic ev;
  logic [5:0] idx;
  logic [31:0] code;
  logic [6:0] fl;
  logic [1:0] col;
  int mismatches = 0;
  int num_checks = 0;
  localparam logic [63:0] IMPL = 64'h00FFFFFFFFFFFFFF;
  localparam logic [63:0] A1 = 64'h0000123456789AB0;

  always #50 core_clk_i = ~core_clk_i;

  mcb_bank #(.ENABLE_IMPL(IMPL), .ADDR_IMPL(1'b1), .MISC_IMPL(1'b0)) u_mcb_bank (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .global_capability_register_i(cap),
    .legacy_mode_i(legacy), .first_bank_i(first), .msr_req_i(msr_req_i), .msr_we_i(msr_we_i),
    .msr_sel_i(msr_sel_i), .msr_wdata_i(msr_wdata_i), .msr_ack_o(msr_ack_o),
    .msr_gp_fault_o(msr_gp_fault_o), .msr_rdata_o(msr_rdata_o), .evt_valid_i(ev),
    .evt_src_idx_i(idx), .evt_mca_code_i(code[15:0]), .evt_model_code_i(code[31:16]),
    .evt_uc_i(fl[0]), .evt_pcc_i(fl[1]), .evt_monitored_i(fl[2]), .evt_color_i(col),
    .evt_signal_i(fl[4]), .evt_ar_i(fl[5]), .evt_addr_valid_i(fl[3]), .evt_addr_i(addr),
    .evt_misc_valid_i(fl[6]));

  mcb_err_src u_mcb_err_src (.core_clk_i(core_clk_i), .evt_valid_o(ev), .idx_o(idx),
    .code_o(code), .flag_o(fl), .color_o(col), .addr_o(addr));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register access; a faulted or write access does not compare read data
  task automatic acc(input logic we, input mcb_sel_t s, input logic [63:0] wd,
                     input logic gp, input logic [63:0] rd);
    @(posedge core_clk_i);
    msr_req_i <= 1'b1;
    msr_we_i <= we;
    msr_sel_i <= s;
    msr_wdata_i <= wd;
    @(posedge core_clk_i);
    msr_req_i <= 1'b0;
    msr_wdata_i <= ~wd;
    #1;
    chk({63'h0, msr_ack_o}, 64'h1);
    chk({63'h0, msr_gp_fault_o}, {63'h0, gp});
    if (!we && !gp) chk(msr_rdata_o, rd);
  endtask

  // Expected status with all capability fields visible and no auxiliary register
  function automatic logic [63:0] st(input logic [31:0] c, input logic [6:0] f, input logic [1:0] k,
                                     input logic en, input logic ov, input logic [14:0] n);
    st = {1'b1, ov, f[0], en, 1'b0, f[3], f[1], f[4], f[5], k, n, 6'h00, c};
  endfunction

  task automatic t_enable();
    acc(1'b0, MCB_SEL_ENABLE, 64'h0, 1'b0, 64'h0);
    acc(1'b1, MCB_SEL_ENABLE, 64'hFFFFFFFFFFFFFFFF, 1'b0, 64'h0);
    acc(1'b0, MCB_SEL_ENABLE, 64'h0, 1'b0, IMPL);
    acc(1'b1, MCB_SEL_ENABLE, 64'hA5A5A5A5A5A5A5A5, 1'b0, 64'h0);
    acc(1'b0, MCB_SEL_ENABLE, 64'h0, 1'b0, 64'h00A5A5A5A5A5A5A5);
    legacy <= 1'b1;
    acc(1'b1, MCB_SEL_ENABLE, 64'h0000000000001234, 1'b1, 64'h0);
    acc(1'b0, MCB_SEL_ENABLE, 64'h0, 1'b0, 64'h00A5A5A5A5A5A5A5);
    acc(1'b1, MCB_SEL_ENABLE, 64'h0, 1'b0, 64'h0);
    acc(1'b0, MCB_SEL_ENABLE, 64'h0, 1'b0, 64'h0);
    first <= 1'b1;
    acc(1'b1, MCB_SEL_ENABLE, 64'hFFFFFFFFFFFFFFFF, 1'b0, 64'h0);
    acc(1'b0, MCB_SEL_ENABLE, 64'h0, 1'b0, 64'h0);
    first <= 1'b0;
    acc(1'b1, MCB_SEL_ENABLE, 64'hFFFFFFFFFFFFFFFF, 1'b0, 64'h0);
    legacy <= 1'b0;
    acc(1'b0, MCB_SEL_ENABLE, 64'h0, 1'b0, IMPL);
  endtask

  task automatic t_faults();
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, 64'h0);
    acc(1'b1, MCB_SEL_STATUS, 64'h8000000000000000, 1'b1, 64'h0);
    acc(1'b1, MCB_SEL_ADDRESS, 64'h0000000000000001, 1'b1, 64'h0);
    acc(1'b0, MCB_SEL_NONE, 64'h0, 1'b1, 64'h0);
  endtask

  // Overwrite order: green, yellow, green, uc, uc into one enabled slot
  task automatic t_overflow();
    u_mcb_err_src.post(6'd5, 32'h11110001, 7'h0E, 2'h1, A1);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h11110001, 7'h0E, 2'h1, 1, 0, 15'd1));
    acc(1'b0, MCB_SEL_ADDRESS, 64'h0, 1'b0, A1);
    u_mcb_err_src.post(6'd5, 32'h22220002, 7'h04, 2'h2, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h22220002, 7'h04, 2'h2, 1, 1, 15'd2));
    u_mcb_err_src.post(6'd5, 32'h33330003, 7'h04, 2'h1, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h22220002, 7'h04, 2'h2, 1, 1, 15'd3));
    u_mcb_err_src.post(6'd5, 32'h44440004, 7'h73, 2'h0, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h44440004, 7'h33, 2'h0, 1, 1, 15'd3));
    u_mcb_err_src.post(6'd5, 32'h55550005, 7'h01, 2'h0, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h44440004, 7'h33, 2'h0, 1, 1, 15'd3));
    acc(1'b1, MCB_SEL_STATUS, 64'h0, 1'b0, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, 64'h0);
    acc(1'b0, MCB_SEL_ADDRESS, 64'h0, 1'b0, A1);
    acc(1'b1, MCB_SEL_ADDRESS, 64'h0, 1'b0, 64'h0);
    acc(1'b0, MCB_SEL_ADDRESS, 64'h0, 1'b0, 64'h0);
  endtask

  // Bit 60 of the enable word is unimplemented, so that source stays disabled
  task automatic t_disabled();
    u_mcb_err_src.post(6'd60, 32'h66660006, 7'h01, 2'h0, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h66660006, 7'h01, 2'h0, 0, 0, 15'd0));
    u_mcb_err_src.post(6'd5, 32'h77770007, 7'h04, 2'h1, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h77770007, 7'h04, 2'h1, 1, 1, 15'd1));
    cap <= 64'h0;
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0,
        st(32'h77770007, 7'h04, 2'h1, 1, 1, 15'd1) & ~64'h01FFFFC000000000);
    cap <= 64'h0000000001000C00;
  endtask

  // Enough corrected events to wrap the low count bits; the unmonitored source offers a colour
  task automatic t_wrap();
    acc(1'b1, MCB_SEL_STATUS, 64'h0, 1'b0, 64'h0);
    repeat (16'h4000) u_mcb_err_src.post(6'h05, 32'h88880008, 7'h00, 2'h2, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h88880008, 7'h00, 2'h0, 1'b1, 1'b1, 15'h4000));
    u_mcb_err_src.post(6'h05, 32'h99990009, 7'h00, 2'h1, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, st(32'h99990009, 7'h00, 2'h0, 1'b1, 1'b1, 15'h4001));
    acc(1'b1, MCB_SEL_STATUS, 64'h0, 1'b0, 64'h0);
    acc(1'b0, MCB_SEL_STATUS, 64'h0, 1'b0, 64'h0);
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_enable();
    t_faults();
    t_overflow();
    t_disabled();
    t_wrap();
    close_out();
  end

  // The counter wrap alone takes about 33,000 cycles; a limit of 40,000 cycles, some 7,000 beyond the whole sequence, means a hang
  initial begin
    #(40000 * 100);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
